// ===== hdl/lpa_alarm_status.sv
// Purpose: three-channel receive alarm status with an Avalon-MM register slave
// Assumes: word-aligned byte addresses; registers answer one cycle after request
// Notes: all status bytes read-only; unmapped reads return zero
`timescale 1ns/1ps
`include "lpa_regs.svh"
module lpa_alarm_status
	import lpa_pkg::*;
#(
	parameter int NCH        = 3,
	parameter int DLOS_ZEROS = `LPA_DLOS_ZEROS,
	parameter int DENS_WIN   = `LPA_DENS_WINDOW,
	parameter int PAT_WIN    = `LPA_PAT_WINDOW
) (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic [9:0]      avs_address,
	input  wire logic            avs_read,
	input  wire logic            avs_write,
	input  wire logic [31:0]     avs_writedata,
	input  wire logic [3:0]      avs_byteenable,
	output logic      [31:0]     avs_readdata,
	output logic                 avs_waitrequest,
	input  wire logic [NCH-1:0]  rx_bit_en,
	input  wire logic [NCH-1:0]  rx_bit,
	input  wire logic [NCH-1:0]  analog_los,
	input  wire logic [NCH-1:0]  chk_en,
	input  wire logic [NCH-1:0]  tx_dmo,
	input  wire logic [NCH-1:0]  rx_lol,
	input  wire logic [NCH-1:0]  fifo_limit,
	output logic      [NCH-1:0]  los_out
);
	logic [NCH-1:0] dlos, ploss;
	logic [7:0]     stat [NCH];
	lpa_bus_st_t    st_q, st_d;
	logic [31:0]    rdata_d;

	function automatic int chan_of(input logic [9:0] adr);
		unique case (adr[9:2])
			`LPA_ALARM_CH0_IDX: chan_of = 0;
			`LPA_ALARM_CH1_IDX: chan_of = 1;
			`LPA_ALARM_CH2_IDX: chan_of = 2;
			default:            chan_of = -1;
		endcase
	endfunction : chan_of

	// ==========================================================
	// per-channel detectors and status bytes
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		lpa_chan #(
			.DLOS_ZEROS (DLOS_ZEROS),
			.DENS_WIN   (DENS_WIN),
			.PAT_WIN    (PAT_WIN)
		) u_chan (
			.clk          (clk),
			.rst          (rst),
			.rx_bit_en    (rx_bit_en[c]),
			.rx_bit       (rx_bit[c]),
			.chk_en       (chk_en[c]),
			.dlos_q       (dlos[c]),
			.plock_loss_q (ploss[c])
		);
		assign los_out[c] = analog_los[c] | dlos[c];
		always_comb begin
			stat[c] = `LPA_ALARM_RESET;
			stat[c][`LPA_BIT_UNUSED] = 1'b0;
			stat[c][`LPA_BIT_PLOSS]  = ploss[c];
			stat[c][`LPA_BIT_DLOS]   = dlos[c];
			stat[c][`LPA_BIT_ALOS]   = analog_los[c];
			stat[c][`LPA_BIT_FL]     = fifo_limit[c];
			stat[c][`LPA_BIT_LOL]    = rx_lol[c];
			stat[c][`LPA_BIT_LOS]    = los_out[c];
			stat[c][`LPA_BIT_TXDMO]  = tx_dmo[c];
		end
	end

	// ==========================================================
	// avalon slave: one wait cycle, then answer
	assign avs_waitrequest = (avs_read | avs_write) && st_q == LPA_BUS_IDLE;

	always_comb begin
		int ch;
		ch      = chan_of(avs_address);
		st_d    = LPA_BUS_IDLE;
		rdata_d = avs_readdata;
		unique case (st_q)
			LPA_BUS_IDLE: begin
				if (avs_read || avs_write)
					st_d = LPA_BUS_ANSWER;
				if (avs_read)
					rdata_d = (ch >= 0 && ch < NCH) ? {24'h000000, stat[ch]} : 32'h00000000;
			end
			LPA_BUS_ANSWER: begin
				st_d = LPA_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q         <= LPA_BUS_IDLE;
			avs_readdata <= 32'h00000000;
		end else begin
			st_q         <= st_d;
			avs_readdata <= rdata_d;
		end
	end

	// ==========================================================
	// checks
	bus_answer_a: assert property (@(posedge clk) disable iff (rst)
		(avs_read && st_q == LPA_BUS_IDLE) |=> !avs_waitrequest)
		else $error("read not answered after one wait cycle");
	los_or_a: assert property (@(posedge clk) disable iff (rst)
		los_out == (analog_los | dlos))
		else $error("signal loss is not the or of both detectors");
	ch0_read_a: assert property (@(posedge clk) disable iff (rst)
		(avs_read && st_q == LPA_BUS_IDLE && avs_address[9:2] == `LPA_ALARM_CH0_IDX)
		|=> avs_readdata[`LPA_BIT_LOS] == $past(los_out[0])
		&& avs_readdata[`LPA_BIT_PLOSS] == $past(ploss[0])
		&& avs_readdata[31:7] == '0)
		else $error("channel 0 status read wrong");
	rd_cover_c: cover property (@(posedge clk) disable iff (rst) avs_read && !avs_waitrequest);
	wr_cover_c: cover property (@(posedge clk) disable iff (rst) avs_write && !avs_waitrequest);
endmodule : lpa_alarm_status

// ===== hdl/lpa_chan.sv
// Purpose: one channel's digital signal-loss detector and pattern-lock monitor
// Assumes: one received bit per rx_bit_en pulse; inputs synchronous to clk
// Notes: pattern is the 2^15-1 sequence x^15+x^14+1, checker self-seeds
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "lpa_regs.svh"
module lpa_chan
	import lpa_pkg::*;
#(
	parameter int DLOS_ZEROS = `LPA_DLOS_ZEROS,
	parameter int DENS_WIN   = `LPA_DENS_WINDOW,
	parameter int PAT_WIN    = `LPA_PAT_WINDOW
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic rx_bit_en,
	input  wire logic rx_bit,
	input  wire logic chk_en,
	output logic      dlos_q,
	output logic      plock_loss_q
);
	localparam int ZW = $clog2(DLOS_ZEROS + 1);
	localparam int DW = $clog2(DENS_WIN + 1);
	localparam int PW = $clog2(PAT_WIN + 1);
	localparam logic [DW-1:0] DENS_NEED =
		DW'((DENS_WIN * `LPA_DENS_PCT + 99) / 100);

	logic [ZW-1:0] zeros_q, zeros_d;
	logic [DW-1:0] wcnt_q, wcnt_d, ones_q, ones_d;
	logic          dlos_d;
	logic [14:0]   prbs_q, prbs_d;
	logic [PW-1:0] pcnt_q, pcnt_d, errs_q, errs_d;
	logic          ploss_d;
	logic          exp_bit;

	// ==========================================================
	// digital signal-loss detector
	always_comb begin
		zeros_d = zeros_q;
		wcnt_d  = wcnt_q;
		ones_d  = ones_q;
		dlos_d  = dlos_q;
		if (rx_bit_en) begin
			zeros_d = rx_bit ? '0 : (zeros_q == ZW'(DLOS_ZEROS) ? zeros_q : zeros_q + 1'b1);
			if (!rx_bit && zeros_q == ZW'(DLOS_ZEROS - 1))
				dlos_d = 1'b1;
			ones_d = ones_q + DW'(rx_bit);
			wcnt_d = wcnt_q + 1'b1;
			if (wcnt_q == DW'(DENS_WIN - 1)) begin
				if (ones_d >= DENS_NEED)
					dlos_d = 1'b0;
				wcnt_d = '0;
				ones_d = '0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			zeros_q <= '0;
			wcnt_q  <= '0;
			ones_q  <= '0;
			dlos_q  <= 1'b0;
		end else begin
			zeros_q <= zeros_d;
			wcnt_q  <= wcnt_d;
			ones_q  <= ones_d;
			dlos_q  <= dlos_d;
		end
	end

	// ==========================================================
	// pattern-lock monitor
	assign exp_bit = prbs_q[14] ^ prbs_q[13];

	always_comb begin
		prbs_d  = prbs_q;
		pcnt_d  = pcnt_q;
		errs_d  = errs_q;
		ploss_d = plock_loss_q;
		if (!chk_en) begin
			pcnt_d = '0;
			errs_d = '0;
		end else if (rx_bit_en) begin
			// while unlocked reload from the line so the checker can re-seed
			prbs_d = {prbs_q[13:0], plock_loss_q ? rx_bit : exp_bit};
			errs_d = errs_q + PW'(rx_bit != exp_bit);
			pcnt_d = pcnt_q + 1'b1;
			if (pcnt_q == PW'(PAT_WIN - 1)) begin
				if (errs_d >= PW'(`LPA_PAT_BAD_ERRS))
					ploss_d = 1'b1;
				else if (errs_d <= PW'(`LPA_PAT_GOOD_ERRS))
					ploss_d = 1'b0;
				pcnt_d = '0;
				errs_d = '0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prbs_q       <= '0;
			pcnt_q       <= '0;
			errs_q       <= '0;
			plock_loss_q <= 1'b0;
		end else begin
			prbs_q       <= prbs_d;
			pcnt_q       <= pcnt_d;
			errs_q       <= errs_d;
			plock_loss_q <= ploss_d;
		end
	end

	// ==========================================================
	// checks
	dlos_declare_a: assert property (@(posedge clk) disable iff (rst)
		(rx_bit_en && !rx_bit && zeros_q == ZW'(DLOS_ZEROS - 1)) |=> dlos_q)
		else $error("digital signal loss not declared after zero run");
	dlos_hold_a: assert property (@(posedge clk) disable iff (rst)
		(!dlos_q ##1 dlos_q) |-> $past(rx_bit_en) && !$past(rx_bit))
		else $error("digital signal loss declared without a missing pulse");
	dlos_clear_a: assert property (@(posedge clk) disable iff (rst)
		(dlos_q ##1 !dlos_q) |-> $past(wcnt_q) == DW'(DENS_WIN - 1))
		else $error("digital signal loss cleared outside a density window end");
	plock_idle_a: assert property (@(posedge clk) disable iff (rst)
		!chk_en |=> $stable(plock_loss_q))
		else $error("pattern lock changed with checker off");
	plock_change_a: assert property (@(posedge clk) disable iff (rst)
		$changed(plock_loss_q) |-> $past(pcnt_q) == PW'(PAT_WIN - 1))
		else $error("pattern lock changed outside window end");
	dlos_seen_c: cover property (@(posedge clk) disable iff (rst) !dlos_q ##1 dlos_q);
	dlos_gone_c: cover property (@(posedge clk) disable iff (rst) dlos_q ##1 !dlos_q);
	plock_back_c: cover property (@(posedge clk) disable iff (rst) plock_loss_q ##1 !plock_loss_q);
endmodule : lpa_chan

// ===== hdl/lpa_pkg.sv
// Purpose: shared types of the channel alarm status block
// Assumes: nothing beyond the register header
// Notes: holds the types only
package lpa_pkg;
	typedef enum logic [1:0] {
		LPA_BUS_IDLE,
		LPA_BUS_ANSWER
	} lpa_bus_st_t;
endpackage : lpa_pkg

// ===== hdl/lpa_regs.svh
// Purpose: register map and timing constants of the channel alarm status block
// Assumes: three channels, one status byte each, word-aligned on the bus
// Notes: included by the design modules
`ifndef LPA_REGS_SVH
`define LPA_REGS_SVH

// ==========================================================
// register indices and reset value (byte address is four times the index)
`define LPA_ALARM_CH0_IDX  8'h03
`define LPA_ALARM_CH1_IDX  8'h0b
`define LPA_ALARM_CH2_IDX  8'h13
`define LPA_ALARM_RESET    8'h00

// ==========================================================
// alarm status byte fields
`define LPA_BIT_TXDMO      0
`define LPA_BIT_LOS        1
`define LPA_BIT_LOL        2
`define LPA_BIT_FL         3
`define LPA_BIT_ALOS       4
`define LPA_BIT_DLOS       5
`define LPA_BIT_PLOSS      6
`define LPA_BIT_UNUSED     7

// ==========================================================
// detector counts (zero run and windows in bit periods, density in percent)
`define LPA_DLOS_ZEROS     160
`define LPA_DENS_WINDOW    32
`define LPA_DENS_PCT       33
`define LPA_PAT_WINDOW     64
`define LPA_PAT_BAD_ERRS   16
`define LPA_PAT_GOOD_ERRS  1

`endif

// ===== tb/lpa_line_model.sv
// Purpose: line-side receive stream model for the alarm status block
// Assumes: one bit per clock, mode chosen by the bench
// Notes: mode 0 silence, 1 clean pattern, 2 inverted pattern
`timescale 1ns/1ps
module lpa_line_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [1:0] mode,
	output logic            bit_en,
	output logic            bit_o
);
	// ==========================================================
	// pattern source
	logic [14:0] s_q;
	logic        fb;
	assign fb = s_q[14] ^ s_q[13];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q    <= 15'h0001;
			bit_en <= 1'b0;
			bit_o  <= 1'b0;
		end else begin
			s_q    <= {s_q[13:0], fb};
			bit_en <= 1'b1;
			bit_o  <= (mode == 2'h1) ? fb : ((mode == 2'h2) ? ~fb : 1'b0);
		end
	end
endmodule : lpa_line_model

// ===== tb/tb.sv
// Purpose: self-checking bench of the alarm status block
// Assumes: one wait state per bus access
// Notes: all channels see the same line stream
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	import lpa_pkg::*;
	logic        clk, rst, rd, wr, wreq, ben, bo;
	logic [9:0]  addr;
	logic [31:0] wdata, rdata, got;
	logic [2:0]  alos, chk, dmo, lol, fl, los;
	logic [1:0]  mode;
	int          error_cnt, samples_checked, cyc;

	lpa_line_model u_line (.clk(clk), .rst(rst), .mode(mode), .bit_en(ben), .bit_o(bo));
	lpa_alarm_status u_dut (.clk(clk), .rst(rst), .avs_address(addr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf),
		.avs_readdata(rdata), .avs_waitrequest(wreq), .rx_bit_en({3{ben}}),
		.rx_bit({3{bo}}), .analog_los(alos), .chk_en(chk), .tx_dmo(dmo),
		.rx_lol(lol), .fifo_limit(fl), .los_out(los));

	// ==========================================================
	// clock, timeout and closing
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("errors=%0d checks=%0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	// ==========================================================
	// bus access: hold until waitrequest is seen low
	task automatic bus(input logic w, input logic [9:0] a, output logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		rd    <= ~w;
		wr    <= w;
		wdata <= 32'hffffffff;
		// wreq and rdata are read at the edge, before the design updates them
		@(posedge clk);
		while (wreq) @(posedge clk);
		d = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	function automatic logic [31:0] exb(input int c, input logic pl, input logic dl);
		return {24'h0, 1'b0, pl, dl, alos[c], fl[c], lol[c], dl | alos[c], dmo[c]};
	endfunction : exb

	task automatic chk_all(input logic [2:0] pl, input logic [2:0] dl);
		@(negedge clk);
		`CHK(los, alos | dl)
		for (int c = 0; c < 3; c++) begin
			bus(1'b0, 10'h00c + 10'(c) * 10'h020, got);
			`CHK(got, exb(c, pl[c], dl[c]))
		end
	endtask : chk_all

	// ==========================================================
	// scenarios
	task automatic t_reset();
		chk_all(3'h0, 3'h0);
		bus(1'b1, 10'h00c, got);
		bus(1'b1, 10'h04c, got);
		chk_all(3'h0, 3'h0);
		bus(1'b0, 10'h010, got);
		`CHK(got, 32'h0)
	endtask : t_reset

	task automatic t_dlos();
		repeat (170) @(posedge clk);
		chk_all(3'h0, 3'h7);
		mode <= 2'h1;
		repeat (300) @(posedge clk);
		chk_all(3'h0, 3'h0);
	endtask : t_dlos

	task automatic t_alos();
		alos <= 3'h5;
		dmo  <= 3'h3;
		lol  <= 3'h6;
		fl   <= 3'h2;
		repeat (2) @(posedge clk);
		chk_all(3'h0, 3'h0);
	endtask : t_alos

	task automatic t_prbs();
		chk  <= 3'h3;
		mode <= 2'h2;
		repeat (200) @(posedge clk);
		chk_all(3'h3, 3'h0);
		mode <= 2'h1;
		repeat (200) @(posedge clk);
		chk_all(3'h0, 3'h0);
	endtask : t_prbs

	// lock lost again, then a reset in mid-run must clear it
	task automatic t_rst_mid();
		mode <= 2'h2;
		repeat (150) @(posedge clk);
		chk_all(3'h3, 3'h0);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk_all(3'h0, 3'h0);
	endtask : t_rst_mid

	initial begin
		rst  = 1'b1;
		{rd, wr, addr, wdata} = '0;
		{alos, chk, dmo, lol, fl} = '0;
		mode = 2'h0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_dlos();
		t_alos();
		t_prbs();
		t_rst_mid();
		end_sim();
	end
endmodule : tb
